// ==== cbsp_cell_layer_model.sv ====
// Purpose: Cell-layer model facing cbsp_line_side
// Assumes: Free-running 200 ns link clocks of unrelated phase
// Notes:   Drives on link falling edges, samples rx data on rising, polls space and cell-available on falling
`timescale 1ns/1ps
module cbsp_cell_layer_model (
  output reg        tx_clock_in,
  output reg        tx_enable_n,
  output reg        tx_start_of_cell,
  output reg [31:0] tx_word_bus,
  output reg        tx_odd_parity,
  input wire        tx_space_available,
  output reg        rx_clock_in,
  output reg        rx_enable_n,
  input wire        rx_start_of_cell,
  input wire [31:0] rx_word_bus,
  input wire        rx_odd_parity,
  input wire        rx_cell_available
);
  reg [31:0] rx_got [0:12];
  integer    rx_idx, rx_sof_cnt, rx_par_bad, i;
  // Supplied clocks run free, both ends use them
  initial begin
    {tx_clock_in, rx_clock_in, tx_start_of_cell, tx_odd_parity, tx_enable_n, rx_enable_n} = 6'h03;
    tx_word_bus = 32'h0;
    rx_idx = 13;
    rx_sof_cnt = 0;
    rx_par_bad = 0;
    fork
      forever #100 tx_clock_in = ~tx_clock_in;
      #37 forever #100 rx_clock_in = ~rx_clock_in;
    join
  end
  // Idle cycle: data keeps moving so stale words cannot pass
  task tx_idle;
    begin
      tx_enable_n <= 1'b1;
      tx_start_of_cell <= 1'b0;
      tx_word_bus <= ~tx_word_bus;
      @(negedge tx_clock_in);
    end
  endtask
  // Caller stands at a link falling edge
  task send_cell(input [31:0] base, input bad_last, input [4:0] n);
    begin
      while (tx_space_available !== 1'b1) tx_idle;
      // Space is not looked at inside a cell
      for (i = 0; i < n; i = i + 1) begin
        tx_enable_n <= 1'b0;
        tx_start_of_cell <= (i == 0);
        tx_word_bus <= base + i;
        tx_odd_parity <= ~^(base + i) ^ (bad_last && i == n - 1);
        @(negedge tx_clock_in);
      end
    end
  endtask
  task read_cell;
    begin
      @(negedge rx_clock_in);
      while (rx_cell_available !== 1'b1) @(negedge rx_clock_in);
      rx_enable_n <= 1'b0;
      repeat (11) @(negedge rx_clock_in);
      rx_enable_n <= 1'b1;
    end
  endtask
  // One word per link rise once a cell starts
  always @(posedge rx_clock_in) begin
    if (rx_start_of_cell === 1'b1) begin
      rx_idx = 0;
      rx_sof_cnt = rx_sof_cnt + 1;
    end
    if (rx_idx < 13) begin
      rx_got[rx_idx] = rx_word_bus;
      if (^{rx_word_bus, rx_odd_parity} !== 1'b1) rx_par_bad = rx_par_bad + 1;
      rx_idx = rx_idx + 1;
    end
  end
endmodule

// ==== cbsp_defs.vh ====
// Purpose: Constants for the single-port cell bus line-side device
// Assumes: 32-bit word path, link clocks sampled by the 40 MHz core clock
// Notes:   Cell length selected by a static format input
`ifndef CBSP_DEFS_VH
`define CBSP_DEFS_VH
`define CBSP_WIDTH        32
`define CBSP_BYTES        4
`define CBSP_WORDS_STD    6'h0D
`define CBSP_WORDS_EXT    6'h0E
`define CBSP_CELL_SLOTS   2
`define CBSP_DEPTH_W      6
`define CBSP_CELL_IDX_W   7
`define CBSP_RESP_CYCLES  2
`endif

// ==== cbsp_line_side.v ====
// Purpose: Line-side end of a single-port cell bus, both directions
// Assumes: Link clocks are slow inputs sampled by clk; one link edge per several clk
// Notes:   Tx cells land in a two-cell buffer, rx cells come from a two-cell buffer
`timescale 1ns/1ps
`include "cbsp_defs.vh"
// Operation
// [RL1] 16-bit path carries 52-octet cells, header two octets per word, then payload.
// [RL2] 16-bit 54-octet cell optional, HEC in first user-defined octet after header.
// [RL3] 8-bit path: 52-octet mandatory, 53-octet optional with HEC first user octet.
// [RL4] 32-bit: 52-octet mandatory, 56-octet adds one user-defined word after header.
// [RL5] Highest data line is MSB, line zero LSB, both directions.
// [RL6] Every answer to a signal across the link comes two link cycles later.
// [RL7] Interface inputs and outputs are registered on both ends.
// [RL8] Cell-layer asserts transmit enable in the first cycle of a cell.
// [RL9] Cell-layer raises transmit start-of-cell only in a cell's first cycle.
// [RL10] Transmit signals use the transmit clock, receive signals the receive clock.
// [RL11] Parity line makes data word plus parity odd in ones.
// [RL12] Cell-layer starts receive transfers by asserting receive enable low.
// [RL13] Receive start-of-cell high only in the first cycle of each cell.
// [RL14] Cell-available asserted only while a complete receive cell is buffered.
// [RL15] Transmit space-available shows room for at least one whole cell.
// [RL16] Words of a cell move on consecutive cycles without pause.
// [RL17] Cell-layer holds enables low across cells, releasing only to pause.
// [RL18] Cell-layer starts a cell only after space-available was signalled.
// [RL19] Cell-layer ignores space-available the cycle after start-of-cell.
// [RL20] From second cycle after start, space needs room beyond the current cell.
// [RL21] Once asserted, space-available holds until edge after next start-of-cell.
// [RL22] After idle, start-of-cell rises with the first data word.
// [RL23] Without space-available the cell-layer withholds queued cells.
// [RL24] Receive data appears two cycles after receive enable is asserted.
// [RL25] Earliest cell octet sits in the most significant byte lane.
// [RL26] Receiver checks odd parity per word and flags mismatches.
module cbsp_line_side (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ext_format,
  input  wire        tx_clock_in,
  input  wire        tx_enable_n,
  input  wire        tx_start_of_cell,
  input  wire [31:0] tx_word_bus,
  input  wire        tx_odd_parity,
  output reg         tx_space_available,
  input  wire        rx_clock_in,
  input  wire        rx_enable_n,
  output reg         rx_start_of_cell,
  output reg  [31:0] rx_word_bus,
  output reg         rx_odd_parity,
  output reg         rx_cell_available,
  input  wire        load_valid,
  input  wire [31:0] load_word,
  output reg         load_ready,
  output reg         drain_valid,
  output reg  [31:0] drain_word,
  output reg         drain_sof,
  input  wire        drain_ready,
  output reg         tx_parity_error
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CELL = 2'b10;

  // Odd parity bit for a word, used on both directions
  function odd_par;
    input [31:0] w;
    begin
      odd_par = ~(^w); // [RL11]
    end
  endfunction

  // Words per cell; 32-bit path only, narrow paths [RL1] [RL2] [RL3] not built
  function [5:0] cell_words;
    input ext;
    begin
      cell_words = ext ? `CBSP_WORDS_EXT : `CBSP_WORDS_STD; // [RL4]
    end
  endfunction

  // Buffer slot of a word: second cell starts past the longest cell
  function [4:0] slot_addr;
    input       sel;
    input [5:0] idx;
    reg   [5:0] sum;
    begin
      sum       = idx + (sel ? `CBSP_WORDS_EXT : 6'h00);
      slot_addr = sum[4:0];
    end
  endfunction

  // Synchronise every link input before use; registered both ways [RL7]
  wire [35:0] tx_s;
  wire [2:0]  rx_s;
  cbsp_sync #(.W(36)) u_tx_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({tx_clock_in, tx_enable_n, tx_start_of_cell, tx_odd_parity, tx_word_bus}),
    .q      (tx_s)
  );
  // Format pin is static but still comes from outside, so it rides here too
  cbsp_sync #(.W(3)) u_rx_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({ext_format, rx_clock_in, rx_enable_n}),
    .q      (rx_s)
  );

  // Link clock edge detectors on synchronised copies only
  reg  txc_d_reg;
  reg  rxc_d_reg;
  wire tx_rise = tx_s[35] & ~txc_d_reg; // [RL10]
  wire rx_rise = rx_s[1] & ~rxc_d_reg;  // [RL10]
  wire rx_fall = ~rx_s[1] & rxc_d_reg;

  // Storage: two cells per direction, 14 words each
  reg [31:0] tx_mem [0:27];
  reg [31:0] rx_mem [0:27];
  reg [1:0]  tx_cnt_reg;
  reg [1:0]  rx_cnt_reg;
  reg        tx_wsel_reg;
  reg        tx_rsel_reg;
  reg        rx_wsel_reg;
  reg        rx_rsel_reg;
  reg [5:0]  tx_widx_reg;
  reg [5:0]  tx_ridx_reg;
  reg [5:0]  rx_widx_reg;
  reg [5:0]  rx_ridx_reg;
  reg [1:0]  tx_st_reg;
  reg [1:0]  rx_st_reg;
  reg [1:0]  rxen_pipe_reg;
  reg        tx_hold_reg;
  reg        drain_busy_reg;
  wire [5:0] last_w  = cell_words(rx_s[2]) - 6'h01;
  wire       tx_done = (tx_st_reg == ST_CELL) && tx_rise && !tx_s[34] && (tx_widx_reg == last_w);
  wire       drain_done = drain_valid && drain_ready && (tx_ridx_reg == last_w);

  // Transmit capture, one word per link rise with enable low, earliest octet in high lane
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txc_d_reg       <= 1'b0;
      tx_st_reg       <= ST_IDLE;
      tx_widx_reg     <= 6'h00;
      tx_wsel_reg     <= 1'b0;
      tx_parity_error <= 1'b0;
    end else begin
      txc_d_reg <= tx_s[35];
      if (tx_rise && !tx_s[34]) begin
        tx_parity_error <= (odd_par(tx_s[31:0]) != tx_s[32]); // [RL26]
        case (tx_st_reg)
          ST_IDLE: begin
            if (tx_s[33]) begin // [RL9]
              tx_mem[slot_addr(tx_wsel_reg, 6'h00)] <= tx_s[31:0]; // [RL25] [RL5]
              tx_widx_reg <= 6'h01;
              tx_st_reg   <= ST_CELL;
            end
          end
          ST_CELL: begin
            tx_mem[slot_addr(tx_wsel_reg, tx_widx_reg)] <= tx_s[31:0]; // [RL16]
            if (tx_widx_reg == last_w) begin
              tx_st_reg   <= ST_IDLE;
              tx_wsel_reg <= ~tx_wsel_reg;
            end else begin
              tx_widx_reg <= tx_widx_reg + 6'h01;
            end
          end
          default: tx_st_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Space flag: room beyond the cell in flight, held until edge after start
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_cnt_reg         <= 2'b00;
      tx_space_available <= 1'b0;
      tx_hold_reg        <= 1'b0;
    end else begin
      tx_cnt_reg <= tx_cnt_reg + {1'b0, tx_done} - {1'b0, drain_done};
      if (tx_rise) begin
        if (tx_space_available && !tx_hold_reg) begin
          tx_hold_reg <= tx_s[33] && !tx_s[34]; // [RL21] reevaluate only on the edge after start
        end else if (tx_st_reg == ST_CELL || (tx_s[33] && !tx_s[34])) begin
          tx_space_available <= (tx_cnt_reg == 2'b00); // [RL20]
          tx_hold_reg        <= 1'b0;
        end else begin
          tx_space_available <= (tx_cnt_reg < 2'b10); // [RL15] [RL6]
          tx_hold_reg        <= 1'b0;
        end
      end
    end
  end

  // Drain side toward the core, stallable
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drain_valid    <= 1'b0;
      drain_word     <= 32'h00000000;
      drain_sof      <= 1'b0;
      tx_ridx_reg    <= 6'h00;
      tx_rsel_reg    <= 1'b0;
      drain_busy_reg <= 1'b0;
    end else begin
      if (drain_valid && drain_ready) begin
        drain_valid <= 1'b0;
        if (drain_done) begin
          tx_ridx_reg <= 6'h00;
          tx_rsel_reg <= ~tx_rsel_reg;
        end else begin
          tx_ridx_reg <= tx_ridx_reg + 6'h01;
        end
      end else if (!drain_valid && tx_cnt_reg != 2'b00 && !drain_busy_reg) begin
        drain_valid <= 1'b1;
        drain_word  <= tx_mem[slot_addr(tx_rsel_reg, tx_ridx_reg)];
        drain_sof   <= (tx_ridx_reg == 6'h00);
      end
      drain_busy_reg <= drain_valid && drain_ready;
    end
  end

  // Receive load from the core into the cell buffer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      load_ready  <= 1'b0;
      rx_widx_reg <= 6'h00;
      rx_wsel_reg <= 1'b0;
    end else begin
      load_ready <= (rx_cnt_reg < 2'b10);
      if (load_valid && load_ready) begin
        rx_mem[slot_addr(rx_wsel_reg, rx_widx_reg)] <= load_word;
        if (rx_widx_reg == last_w) begin
          rx_widx_reg <= 6'h00;
          rx_wsel_reg <= ~rx_wsel_reg;
        end else begin
          rx_widx_reg <= rx_widx_reg + 6'h01;
        end
      end
    end
  end
  wire load_done = load_valid && load_ready && (rx_widx_reg == last_w);
  wire rx_last   = (rx_st_reg == ST_CELL) && (rx_ridx_reg == last_w);
  wire rx_go     = rxen_pipe_reg[1] && (rx_cnt_reg != 2'b00);
  wire send_done = rx_rise && rx_last;

  // Receive launch: data two link cycles after enable, driven on falling link edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxc_d_reg         <= 1'b0;
      rx_cnt_reg        <= 2'b00;
      rx_st_reg         <= ST_IDLE;
      rx_ridx_reg       <= 6'h00;
      rx_rsel_reg       <= 1'b0;
      rxen_pipe_reg     <= 2'b00;
      rx_start_of_cell  <= 1'b0;
      rx_word_bus       <= 32'h00000000;
      rx_odd_parity     <= 1'b1;
      rx_cell_available <= 1'b0;
    end else begin
      rxc_d_reg  <= rx_s[1];
      rx_cnt_reg <= rx_cnt_reg + {1'b0, load_done} - {1'b0, send_done};
      if (rx_rise) begin
        rxen_pipe_reg <= {rxen_pipe_reg[0], ~rx_s[0]}; // [RL12] [RL6]
        if (rx_last) begin
          rx_st_reg   <= ST_IDLE;
          rx_ridx_reg <= 6'h00;
          rx_rsel_reg <= ~rx_rsel_reg;
        end else if (rx_st_reg == ST_CELL) begin
          rx_ridx_reg <= rx_ridx_reg + 6'h01; // [RL16]
        end
      end
      if (rx_fall) begin
        rx_cell_available <= (rx_cnt_reg != 2'b00) && !(rx_cnt_reg == 2'b01 && rx_st_reg == ST_CELL); // [RL14]
        if (rx_st_reg == ST_CELL) begin
          rx_start_of_cell <= 1'b0;
          rx_word_bus      <= rx_mem[slot_addr(rx_rsel_reg, rx_ridx_reg)]; // [RL25]
          rx_odd_parity    <= odd_par(rx_mem[slot_addr(rx_rsel_reg, rx_ridx_reg)]); // [RL11]
        end else if (rx_go) begin
          rx_st_reg        <= ST_CELL;
          rx_start_of_cell <= 1'b1; // [RL13] [RL24]
          rx_word_bus      <= rx_mem[slot_addr(rx_rsel_reg, 6'h00)];
          rx_odd_parity    <= odd_par(rx_mem[slot_addr(rx_rsel_reg, 6'h00)]);
        end else begin
          rx_start_of_cell <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== cbsp_line_side_props.sv ====
// Purpose: Port checks for cbsp_line_side
// Assumes: 200 ns link clocks against a 25 ns core clock
// Notes:   Ages count core cycles since link events and load handshakes
`timescale 1ns/1ps
module cbsp_line_side_props (
  input wire        clk,
  input wire        resetn,
  input wire        tx_clock_in,
  input wire        tx_start_of_cell,
  input wire        tx_space_available,
  input wire        rx_clock_in,
  input wire        rx_enable_n,
  input wire        rx_start_of_cell,
  input wire [31:0] rx_word_bus,
  input wire        rx_odd_parity,
  input wire        rx_cell_available,
  input wire        load_valid,
  input wire        load_ready,
  input wire        drain_valid,
  input wire [31:0] drain_word,
  input wire        drain_ready
);
  reg [7:0] tx_age_reg;
  reg [7:0] rx_age_reg;
  reg [7:0] sof_age_reg;
  reg [7:0] en_age_reg;
  reg [7:0] ld_age_reg;
  function [7:0] inc(input [7:0] a);
    inc = (a == 8'hFF) ? a : a + 8'h01;
  endfunction
  // Saturating ages, so a stale event never wraps back into range
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_age_reg <= 8'hFF;
      rx_age_reg <= 8'hFF;
      sof_age_reg <= 8'hFF;
      en_age_reg <= 8'hFF;
      ld_age_reg <= 8'hFF;
    end else begin
      tx_age_reg <= $rose(tx_clock_in) ? 8'h00 : inc(tx_age_reg);
      rx_age_reg <= $fell(rx_clock_in) ? 8'h00 : inc(rx_age_reg);
      sof_age_reg <= ($rose(tx_clock_in) && tx_start_of_cell) ? 8'h00 : inc(sof_age_reg);
      en_age_reg <= $fell(rx_enable_n) ? 8'h00 : inc(en_age_reg);
      ld_age_reg <= (load_valid && load_ready) ? 8'h00 : inc(ld_age_reg);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_rx_par_odd: assert property (^{rx_word_bus, rx_odd_parity})
    else $error("rx parity even");
  chk_rx_data_edge: assert property (!$stable(rx_word_bus) |-> rx_age_reg <= 8'h05)
    else $error("rx data off link edge");
  chk_space_edge: assert property (!$stable(tx_space_available) |-> tx_age_reg <= 8'h05)
    else $error("space off link edge");
  chk_space_hold: assert property ($fell(tx_space_available) |->
    sof_age_reg >= 8'h06 && sof_age_reg <= 8'h10)
    else $error("space dropped outside a cell");
  chk_rx_sof_once: assert property ($rose(rx_start_of_cell) |->
    rx_start_of_cell [*4] ##[1:6] !rx_start_of_cell) else $error("rx sof width");
  chk_rx_sof_delay: assert property ($rose(rx_start_of_cell) |->
    en_age_reg >= 8'h0A && en_age_reg <= 8'h1C) else $error("rx sof delay");
  chk_drain_stand: assert property (drain_valid && !drain_ready |=>
    drain_valid && $stable(drain_word)) else $error("drain word lost");
  chk_avail_load: assert property ($rose(rx_cell_available) |-> ld_age_reg <= 8'h14)
    else $error("avail without load");
  cover property ($rose(rx_start_of_cell));
  cover property ($fell(tx_space_available));
  cover property (drain_valid && !drain_ready);
endmodule
bind cbsp_line_side cbsp_line_side_props u_props (.clk(clk), .resetn(resetn), .tx_clock_in(tx_clock_in),
  .tx_start_of_cell(tx_start_of_cell), .tx_space_available(tx_space_available), .rx_clock_in(rx_clock_in),
  .rx_enable_n(rx_enable_n), .rx_start_of_cell(rx_start_of_cell), .rx_word_bus(rx_word_bus),
  .rx_odd_parity(rx_odd_parity), .rx_cell_available(rx_cell_available), .load_valid(load_valid),
  .load_ready(load_ready), .drain_valid(drain_valid), .drain_word(drain_word), .drain_ready(drain_ready));

// ==== cbsp_line_side_test.sv ====
// Purpose: Self-checking bench for cbsp_line_side
// Assumes: 13-word cells, 14-word in the ext_format test, two-cell buffers each way
// Notes:   Core side driven on clk falling edges
`timescale 1ns/1ps
module cbsp_line_side_test;
  reg         clk, resetn, load_valid, drain_ready, ext_fmt;
  reg  [31:0] load_word;
  wire        tx_clock_in, tx_enable_n, tx_start_of_cell, tx_odd_parity, tx_space_available;
  wire        rx_clock_in, rx_enable_n, rx_start_of_cell, rx_odd_parity, rx_cell_available;
  wire        load_ready, drain_valid, drain_sof, tx_parity_error;
  wire [31:0] tx_word_bus, rx_word_bus, drain_word;
  integer     bad_count, n_tests, i, g;
  cbsp_line_side dut (.clk(clk), .resetn(resetn), .ext_format(ext_fmt), .tx_clock_in(tx_clock_in),
    .tx_enable_n(tx_enable_n), .tx_start_of_cell(tx_start_of_cell), .tx_word_bus(tx_word_bus),
    .tx_odd_parity(tx_odd_parity), .tx_space_available(tx_space_available), .rx_clock_in(rx_clock_in),
    .rx_enable_n(rx_enable_n), .rx_start_of_cell(rx_start_of_cell), .rx_word_bus(rx_word_bus),
    .rx_odd_parity(rx_odd_parity), .rx_cell_available(rx_cell_available), .load_valid(load_valid),
    .load_word(load_word), .load_ready(load_ready), .drain_valid(drain_valid), .drain_word(drain_word),
    .drain_sof(drain_sof), .drain_ready(drain_ready), .tx_parity_error(tx_parity_error));
  cbsp_cell_layer_model fe (.tx_clock_in(tx_clock_in), .tx_enable_n(tx_enable_n),
    .tx_start_of_cell(tx_start_of_cell), .tx_word_bus(tx_word_bus), .tx_odd_parity(tx_odd_parity),
    .tx_space_available(tx_space_available), .rx_clock_in(rx_clock_in), .rx_enable_n(rx_enable_n),
    .rx_start_of_cell(rx_start_of_cell), .rx_word_bus(rx_word_bus), .rx_odd_parity(rx_odd_parity),
    .rx_cell_available(rx_cell_available));
  task chk32(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task chk1(input got, input exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Odd words stall one cycle so held outputs are exercised
  task drain_cell(input [31:0] base, input [4:0] n);
    for (i = 0; i < n; i = i + 1) begin
      g = 0;
      while (drain_valid !== 1'b1 && g < 400) begin
        drain_ready = 1'b0;
        @(negedge clk);
        g = g + 1;
      end
      if (i % 2) begin
        drain_ready = 1'b0;
        @(negedge clk);
      end
      chk1(drain_valid, 1'b1);
      chk32(drain_word, base + i);
      chk1(drain_sof, i == 0);
      drain_ready = 1'b1;
      @(negedge clk);
    end
  endtask
  task load_cell(input [31:0] base);
    begin
      for (i = 0; i < 13; i = i + 1) begin
        load_valid = 1'b1;
        load_word = base + i;
        g = 0;
        while (load_ready !== 1'b1 && g < 200) begin
          @(negedge clk);
          g = g + 1;
        end
        chk1(load_ready, 1'b1);
        @(negedge clk);
      end
      load_valid = 1'b0;
    end
  endtask
  // Back-to-back cells fill both slots, then a lone cell after idle
  task t_tx;
    begin
      fe.tx_idle;
      fe.send_cell(32'h11000000, 1'b0, 5'h0D);
      fe.send_cell(32'h22000000, 1'b1, 5'h0D);
      fe.tx_idle;
      repeat (40) @(negedge clk);
      chk1(tx_parity_error, 1'b1);
      chk1(tx_space_available, 1'b0);
      drain_cell(32'h11000000, 5'h0D);
      drain_cell(32'h22000000, 5'h0D);
      drain_ready = 1'b0;
      repeat (40) @(negedge clk);
      chk1(tx_space_available, 1'b1);
      fe.tx_idle;
      fe.send_cell(32'h33000000, 1'b0, 5'h0D);
      fe.tx_idle;
      repeat (40) @(negedge clk);
      chk1(tx_parity_error, 1'b0);
      drain_cell(32'h33000000, 5'h0D);
      drain_ready = 1'b0;
    end
  endtask
  // One 56-octet cell, format switched while both directions are idle
  task t_ext;
    begin
      ext_fmt = 1'b1;
      repeat (8) @(negedge clk);
      fe.tx_idle;
      fe.send_cell(32'h44000000, 1'b0, 5'h0E);
      fe.tx_idle;
      repeat (40) @(negedge clk);
      chk1(tx_space_available, 1'b1);
      drain_cell(32'h44000000, 5'h0E);
      drain_ready = 1'b0;
      ext_fmt = 1'b0;
      repeat (8) @(negedge clk);
    end
  endtask
  task t_rx;
    begin
      load_cell(32'h5A000000);
      g = 0;
      while (rx_cell_available !== 1'b1 && g < 100) begin
        @(negedge clk);
        g = g + 1;
      end
      chk1(rx_cell_available, 1'b1);
      fe.read_cell;
      repeat (80) @(negedge clk);
      for (i = 0; i < 13; i = i + 1)
        chk32(fe.rx_got[i], 32'h5A000000 + i);
      chk32(fe.rx_sof_cnt, 32'h1);
      chk32(fe.rx_par_bad, 32'h0);
      chk1(rx_cell_available, 1'b0);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Whole run is near 1000 core cycles
  initial begin
    #1000000;
    bad_count = bad_count + 1;
    stop_test;
  end
  initial begin
    {resetn, load_valid, drain_ready, ext_fmt} = 4'h0;
    load_word = 32'h0;
    bad_count = 0;
    n_tests = 0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (12) @(negedge clk);
    chk1(tx_space_available, 1'b1);
    chk1(rx_odd_parity, 1'b1);
    t_tx;
    t_ext;
    t_rx;
    stop_test;
  end
endmodule

// ==== cbsp_sync.v ====
// Purpose: Two-flop synchroniser for signals arriving from the link side
// Assumes: Destination clock faster than the source toggles
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module cbsp_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         resetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_reg;

  // Plain double register, constants under reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
